// ===== verilog/cctl_pkg.sv
package cctl_pkg;
    // System clock and converter time base
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RC_NOMINAL_HZ = 32768;
    // Instantaneous conversion time in microseconds, and in RC ticks (rounded up)
    localparam int unsigned INST_CONV_US = 3900;
    localparam int unsigned INST_CONV_TICKS = (INST_CONV_US * RC_NOMINAL_HZ + 999999) / 1000000;
    // Modulator samples per conversion, and clk cycles between samples (rounded down)
    localparam int unsigned MOD_SAMPLES = 4096;
    localparam int unsigned MOD_DIV = (INST_CONV_US * 1000) / CLK_PERIOD_NS / MOD_SAMPLES;
    // Base periods in RC ticks for select code 00; each code step doubles
    localparam int unsigned ACC_TICKS_BASE = 4096;
    localparam int unsigned INTERVAL_TICKS_BASE = 8192;
    // Result layout
    localparam int INST_BITS = 13;
    localparam int INST_WIDTH = 16;
    localparam int ACC_BITS = 18;
    localparam int ACC_WIDTH = 32;
    localparam int THR_WIDTH = 8;
    localparam int ACC_SUM_WIDTH = 21;
    localparam logic signed [12:0] INST_MAX = 13'h0fff;
    localparam logic signed [12:0] INST_MIN = 13'h1001;
    // Reset values
    localparam logic [15:0] INST_RESET = 16'h0000;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    // Control bits from the CPU side
    typedef struct packed {
        logic enable;
        logic polarity;
        logic scale;
        logic [1:0] accum_sel;
        logic [1:0] interval_sel;
        logic regular;
    } cctl_ctrl_s;

    // One bit per event: instantaneous, accumulated, regular current
    typedef struct packed {
        logic inst;
        logic acc;
        logic rc;
    } cctl_flags_s;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_CONVERT,
        ST_WAIT
    } cctl_state_e;
endpackage

// ===== verilog/cctl_tick_sync.sv
`timescale 1ns/1ps
module cctl_tick_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rc_osc,
    input wire logic mod_bit_in,
    output logic rc_tick,
    output logic mod_bit
);
    logic [2:0] osc_reg;
    logic [2:0] osc_next;
    logic [1:0] bit_reg;
    logic [1:0] bit_next;

    // Two flops per pin; the third osc stage only feeds the edge detect
    always_comb begin
        osc_next = {osc_reg[1:0], rc_osc};
        bit_next = {bit_reg[0], mod_bit_in};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_reg <= 3'h0;
            bit_reg <= 2'h0;
        end else begin
            osc_reg <= osc_next;
            bit_reg <= bit_next;
        end
    end

    // Rising edge of the RC oscillator as a one-cycle enable
    assign rc_tick = osc_reg[1] & ~osc_reg[2];
    assign mod_bit = bit_reg[1];
endmodule

// ===== verilog/cctl_result_hold.sv
`timescale 1ns/1ps
module cctl_result_hold #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] data_in,
    input wire logic lock_set,
    input wire logic lock_clr,
    output logic [WIDTH-1:0] data_out,
    output logic taken
);
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;
    logic lock_reg;
    logic lock_next;

    // A load during an open read sequence is dropped, and so is its event
    always_comb begin
        taken = load & ~lock_reg & ~lock_set;
        data_next = taken ? data_in : data_reg;
        lock_next = lock_reg;
        if (lock_set) begin
            lock_next = 1'b1;
        end else if (lock_clr) begin
            lock_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= RESET_VALUE;
            lock_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            lock_reg <= lock_next;
        end
    end

    assign data_out = data_reg;
endmodule

// ===== verilog/cctl_coulomb_top.sv
`timescale 1ns/1ps
module cctl_coulomb_top #(
    parameter int unsigned CONV_TICKS = cctl_pkg::INST_CONV_TICKS,
    parameter int unsigned ACC_TICKS = cctl_pkg::ACC_TICKS_BASE,
    parameter int unsigned INTERVAL_TICKS = cctl_pkg::INTERVAL_TICKS_BASE,
    parameter int unsigned MOD_DIV = cctl_pkg::MOD_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rc_osc,
    input wire logic mod_bit_in,
    input wire logic power_off,
    input wire cctl_pkg::cctl_ctrl_s ctrl,
    input wire logic [7:0] charge_threshold,
    input wire logic [7:0] discharge_threshold,
    input wire cctl_pkg::cctl_flags_s int_enable,
    input wire logic global_int_enable,
    input wire cctl_pkg::cctl_flags_s flag_clear,
    input wire logic rd_inst_low,
    input wire logic rd_inst_high,
    input wire logic [3:0] rd_acc_byte,
    output logic [15:0] inst_result,
    output logic [31:0] accum_result,
    output cctl_pkg::cctl_flags_s flags,
    output cctl_pkg::cctl_flags_s irq,
    output logic modulator_enable,
    output logic modulator_polarity,
    output logic ref_half
);
    localparam int TCW = $clog2(CONV_TICKS) + 1;
    localparam int ICW = $clog2(INTERVAL_TICKS * 8) + 1;
    localparam int ACW = $clog2((ACC_TICKS / CONV_TICKS) * 8) + 1;
    localparam int DCW = $clog2(MOD_DIV) + 1;
    localparam int SW = cctl_pkg::ACC_SUM_WIDTH;

    // Reset release synchroniser
    logic rst_meta_reg;
    logic rst_sync_reg;

    // Conversion sequencer
    cctl_pkg::cctl_state_e state_reg;
    cctl_pkg::cctl_state_e state_next;
    logic [TCW-1:0] tick_reg;
    logic [TCW-1:0] tick_next;
    logic [ICW-1:0] ival_reg;
    logic [ICW-1:0] ival_next;
    logic [DCW-1:0] div_reg;
    logic [DCW-1:0] div_next;
    logic signed [12:0] samp_reg;
    logic signed [12:0] samp_next;
    logic regular_reg;
    logic regular_next;

    // Accumulation
    logic signed [SW-1:0] acc_sum_reg;
    logic signed [SW-1:0] acc_sum_next;
    logic [ACW-1:0] acc_cnt_reg;
    logic [ACW-1:0] acc_cnt_next;

    // Flags
    cctl_pkg::cctl_flags_s flags_reg;
    cctl_pkg::cctl_flags_s flags_next;

    logic rc_tick;
    logic mod_bit;
    logic run;
    logic regular_mode;
    logic regular_rise;
    logic conv_done;
    logic acc_load;
    logic [31:0] acc_value;
    logic [15:0] inst_value;
    logic rc_hit;
    logic inst_taken;
    logic acc_taken;
    logic [12:0] samp_mag;

    // Last RC tick index of a sampling interval
    function automatic logic [ICW-1:0] interval_limit(input logic [1:0] sel);
        interval_limit = ICW'((INTERVAL_TICKS << sel) - 1);
    endfunction

    // Last conversion index of an accumulation period
    function automatic logic [ACW-1:0] acc_limit(input logic [1:0] sel);
        acc_limit = ACW'(((ACC_TICKS / CONV_TICKS) << sel) - 1);
    endfunction

    // One up/down step of the decimator, clamped to INST_MIN..INST_MAX (+/-4095)
    function automatic logic signed [12:0] sat_step(input logic signed [12:0] v,
                                                     input logic up);
        if (up) begin
            sat_step = (v == cctl_pkg::INST_MAX) ? v : v + 13'sh0001;
        end else begin
            sat_step = (v == cctl_pkg::INST_MIN) ? v : v - 13'sh0001;
        end
    endfunction

    // Reset asserts at once and releases two edges later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    cctl_tick_sync u_sync (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .rc_osc(rc_osc),
        .mod_bit_in(mod_bit_in),
        .rc_tick(rc_tick),
        .mod_bit(mod_bit)
    );

    // Power-off sleep overrides the enable bit
    assign run = ctrl.enable & ~power_off;
    assign regular_mode = run & ctrl.regular;
    // Entering regular detect aborts the conversion in flight
    assign regular_rise = regular_mode & ~regular_reg;

    // Sequencer: convert, then either convert again or wait an interval
    always_comb begin
        state_next = state_reg;
        tick_next = tick_reg;
        ival_next = ival_reg;
        div_next = div_reg;
        samp_next = samp_reg;
        regular_next = regular_mode;
        conv_done = 1'b0;
        if (!run) begin
            state_next = cctl_pkg::ST_OFF;
            tick_next = '0;
            ival_next = '0;
            div_next = '0;
            samp_next = '0;
        end else if (regular_rise) begin
            state_next = cctl_pkg::ST_CONVERT;
            tick_next = '0;
            ival_next = '0;
            div_next = '0;
            samp_next = '0;
        end else begin
            unique case (state_reg)
                cctl_pkg::ST_OFF: begin
                    state_next = cctl_pkg::ST_CONVERT;
                end
                cctl_pkg::ST_CONVERT: begin
                    if (div_reg == DCW'(MOD_DIV - 1)) begin
                        div_next = '0;
                        // Inverted polarity flips each modulator decision
                        samp_next = sat_step(samp_reg, mod_bit ^ ctrl.polarity);
                    end else begin
                        div_next = div_reg + 1'b1;
                    end
                    if (rc_tick) begin
                        if (tick_reg == TCW'(CONV_TICKS - 1)) begin
                            conv_done = 1'b1;
                            tick_next = '0;
                            div_next = '0;
                            samp_next = '0;
                            if (ctrl.regular) begin
                                state_next = cctl_pkg::ST_WAIT;
                            end
                        end else begin
                            tick_next = tick_reg + 1'b1;
                        end
                    end
                end
                cctl_pkg::ST_WAIT: begin
                    if (rc_tick) begin
                        if (ival_reg == interval_limit(ctrl.interval_sel)) begin
                            ival_next = '0;
                            state_next = cctl_pkg::ST_CONVERT;
                        end else begin
                            ival_next = ival_reg + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= cctl_pkg::ST_OFF;
            tick_reg <= '0;
            ival_reg <= '0;
            div_reg <= '0;
            samp_reg <= '0;
            regular_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tick_reg <= tick_next;
            ival_reg <= ival_next;
            div_reg <= div_next;
            samp_reg <= samp_next;
            regular_reg <= regular_next;
        end
    end

    // Sign-extend the finished sample to the 16-bit presentation
    assign inst_value = {{3{samp_reg[12]}}, samp_reg};

    // Summing 32 << sel samples; shifting by sel leaves an 18-bit average
    always_comb begin
        logic signed [SW-1:0] sum_new;
        logic signed [SW-1:0] shifted;
        sum_new = acc_sum_reg + {{(SW - 13){samp_reg[12]}}, samp_reg};
        shifted = sum_new >>> ctrl.accum_sel;
        acc_sum_next = acc_sum_reg;
        acc_cnt_next = acc_cnt_reg;
        acc_load = 1'b0;
        acc_value = {{14{shifted[17]}}, shifted[17:0]};
        if (!run || ctrl.regular) begin
            // Stays cleared so the first period after regular mode is whole
            acc_sum_next = '0;
            acc_cnt_next = '0;
        end else if (conv_done) begin
            if (acc_cnt_reg == acc_limit(ctrl.accum_sel)) begin
                acc_load = 1'b1;
                acc_sum_next = '0;
                acc_cnt_next = '0;
            end else begin
                acc_sum_next = sum_new;
                acc_cnt_next = acc_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            acc_sum_reg <= '0;
            acc_cnt_reg <= '0;
        end else begin
            acc_sum_reg <= acc_sum_next;
            acc_cnt_reg <= acc_cnt_next;
        end
    end

    // Threshold compare on magnitude, sign picks charge or discharge level
    assign samp_mag = 13'(-samp_reg);
    assign rc_hit = conv_done & regular_mode &
        ((~samp_reg[12] & (samp_reg >= $signed({5'h00, charge_threshold}))) |
         (samp_reg[12] & (samp_mag >= {5'h00, discharge_threshold})));

    cctl_result_hold #(
        .WIDTH(cctl_pkg::INST_WIDTH),
        .RESET_VALUE(cctl_pkg::INST_RESET)
    ) u_inst_hold (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .load(conv_done),
        .data_in(inst_value),
        .lock_set(rd_inst_low),
        .lock_clr(rd_inst_high),
        .data_out(inst_result),
        .taken(inst_taken)
    );

    cctl_result_hold #(
        .WIDTH(cctl_pkg::ACC_WIDTH),
        .RESET_VALUE(cctl_pkg::ACC_RESET)
    ) u_acc_hold (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .load(acc_load),
        .data_in(acc_value),
        .lock_set(|rd_acc_byte[2:0]),
        .lock_clr(rd_acc_byte[3]),
        .data_out(accum_result),
        .taken(acc_taken)
    );

    // Sticky flags; a set in the clearing cycle wins
    always_comb begin
        flags_next.inst = inst_taken | (flags_reg.inst & ~flag_clear.inst);
        flags_next.acc = acc_taken | (flags_reg.acc & ~flag_clear.acc);
        flags_next.rc = rc_hit | (flags_reg.rc & ~flag_clear.rc);
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            flags_reg <= cctl_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
    // Each request needs its own enable and the global enable
    assign irq.inst = flags_reg.inst & int_enable.inst & global_int_enable;
    assign irq.acc = flags_reg.acc & int_enable.acc & global_int_enable;
    assign irq.rc = flags_reg.rc & int_enable.rc & global_int_enable;

    // Analog side controls; modulator is unpowered whenever stopped
    assign modulator_enable = (state_reg != cctl_pkg::ST_OFF);
    assign modulator_polarity = ctrl.polarity;
    assign ref_half = ctrl.scale & run;
endmodule

// ===== verif/cctl_coulomb_sva.sv
`timescale 1ns/1ps
module cctl_coulomb_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic power_off,
    input wire cctl_pkg::cctl_ctrl_s ctrl,
    input wire cctl_pkg::cctl_flags_s int_enable,
    input wire logic global_int_enable,
    input wire logic rd_inst_low,
    input wire logic rd_inst_high,
    input wire logic [3:0] rd_acc_byte,
    input wire logic [15:0] inst_result,
    input wire logic [31:0] accum_result,
    input wire cctl_pkg::cctl_flags_s flags,
    input wire cctl_pkg::cctl_flags_s irq,
    input wire logic modulator_enable,
    input wire logic modulator_polarity,
    input wire logic ref_half
);
    logic [1:0] live_reg;
    logic [1:0] live_next;
    logic inst_lk_reg;
    logic inst_lk_next;
    logic acc_lk_reg;
    logic acc_lk_next;
    // Mirror of the reset release and both read locks
    always_comb begin
        live_next = {live_reg[0], 1'b1};
        inst_lk_next = rd_inst_low ? 1'b1 : (rd_inst_high ? 1'b0 : inst_lk_reg);
        acc_lk_next = (|rd_acc_byte[2:0]) ? 1'b1 : (rd_acc_byte[3] ? 1'b0 : acc_lk_reg);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_reg <= 2'h0;
            inst_lk_reg <= 1'b0;
            acc_lk_reg <= 1'b0;
        end else begin
            live_reg <= live_next;
            inst_lk_reg <= inst_lk_next;
            acc_lk_reg <= acc_lk_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // The unlocking read itself is left out, though its cycle cannot reload; the cycle after it can
    sequence inst_hold_s;
        rd_inst_low || (inst_lk_reg && !rd_inst_high);
    endsequence
    sequence acc_hold_s;
        (|rd_acc_byte[2:0]) || (acc_lk_reg && !rd_acc_byte[3]);
    endsequence
    sequence run_s;
        live_reg[1] && ctrl.enable && !power_off;
    endsequence
    inst_sign_a: assert property (inst_result[15:13] == {3{inst_result[12]}})
        else $error("instantaneous sign extension broken");
    acc_sign_a: assert property (accum_result[31:18] == {14{accum_result[17]}})
        else $error("accumulated sign extension broken");
    inst_load_a: assert property ($changed(inst_result) |-> flags.inst)
        else $error("instantaneous result moved without its flag");
    acc_load_a: assert property ($changed(accum_result) |-> flags.acc)
        else $error("accumulated result moved without its flag");
    inst_freeze_a: assert property (inst_hold_s |=> $stable(inst_result) && !$rose(flags.inst))
        else $error("instantaneous result updated while locked");
    acc_freeze_a: assert property (acc_hold_s |=> $stable(accum_result) && !$rose(flags.acc))
        else $error("accumulated result updated while locked");
    irq_gate_a: assert property (irq == (flags & int_enable & {3{global_int_enable}}))
        else $error("interrupt gating wrong");
    run_on_a: assert property (run_s |=> modulator_enable)
        else $error("modulator idle while enabled");
    run_off_a: assert property (!ctrl.enable || power_off |=> !modulator_enable)
        else $error("modulator running while disabled");
    pin_follow_a: assert property (modulator_polarity == ctrl.polarity
        && ref_half == (ctrl.scale && ctrl.enable && !power_off))
        else $error("polarity or scaling output wrong");
    regular_acc_a: assert property (ctrl.regular ##1 ctrl.regular |=> $stable(accum_result))
        else $error("accumulation updated in regular mode");
endmodule
bind cctl_coulomb_top cctl_coulomb_sva u_cctl_coulomb_sva (.clk, .rst_n, .power_off, .ctrl,
    .int_enable, .global_int_enable, .rd_inst_low, .rd_inst_high, .rd_acc_byte, .inst_result,
    .accum_result, .flags, .irq, .modulator_enable, .modulator_polarity, .ref_half);

// ===== verif/cctl_analog_model.sv
`timescale 1ns/1ps
module cctl_analog_model #(
    parameter int HALF_NS = 400
) (
    input wire logic clk,
    input wire logic modulator_enable,
    input wire logic level,
    output logic rc_osc,
    output logic mod_bit_in
);
    // Free running RC oscillator, phase unrelated to clk
    initial begin
        rc_osc = 1'b0;
        #137;
        forever #(HALF_NS) rc_osc = ~rc_osc;
    end
    // Idle modulator toggles so a stale level is never mistaken for data
    initial mod_bit_in = 1'b0;
    always @(posedge clk) begin
        mod_bit_in <= modulator_enable ? level : ~mod_bit_in;
    end
endmodule

// ===== verif/cctl_coulomb_top_bench.sv
`timescale 1ns/1ps
module cctl_coulomb_top_bench;
    localparam int CT = 4;
    localparam int AT = 128;
    localparam int IT = 8;
    localparam int RCP = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic power_off = 1'b0;
    logic level = 1'b1;
    cctl_pkg::cctl_ctrl_s ctrl = '0;
    logic [7:0] chg_thr = 8'h00;
    logic [7:0] dis_thr = 8'h00;
    cctl_pkg::cctl_flags_s int_en = '0;
    logic gie = 1'b0;
    cctl_pkg::cctl_flags_s fclr = '0;
    logic rd_lo = 1'b0;
    logic rd_hi = 1'b0;
    logic [3:0] rd_acc = 4'h0;
    logic rc_osc, mod_bit_in, mod_en, mod_pol, ref_half;
    logic [15:0] inst_result;
    logic [31:0] accum_result;
    logic [31:0] held;
    cctl_pkg::cctl_flags_s flags, irq;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    always #25 clk = ~clk;
    cctl_coulomb_top #(.CONV_TICKS(CT), .ACC_TICKS(AT), .INTERVAL_TICKS(IT), .MOD_DIV(2))
    u_cctl_coulomb_top (.clk, .rst_n, .rc_osc, .mod_bit_in, .power_off, .ctrl,
        .charge_threshold(chg_thr), .discharge_threshold(dis_thr), .int_enable(int_en),
        .global_int_enable(gie), .flag_clear(fclr), .rd_inst_low(rd_lo), .rd_inst_high(rd_hi),
        .rd_acc_byte(rd_acc), .inst_result, .accum_result, .flags, .irq,
        .modulator_enable(mod_en), .modulator_polarity(mod_pol), .ref_half);
    cctl_analog_model #(.HALF_NS(RCP * 25)) u_cctl_analog_model (.clk,
        .modulator_enable(mod_en), .level, .rc_osc, .mod_bit_in);
    task automatic test_done;
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Periods allow a few cycles for the RC edge synchroniser
    task automatic check_near(input int got, input int exp);
        total_checks++;
        if (got < exp - 4 || got > exp + 4) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Trailing edge so a following call never retouches fclr in the same step
    task automatic clr(input int idx);
        fclr[idx] = 1'b1;
        @(negedge clk);
        fclr[idx] = 1'b0;
        @(negedge clk);
    endtask
    // Cycles until the flag is seen, then pulse its fclr bit to clear it
    task automatic wait_ev(input int idx, output int cyc);
        cyc = 1;
        while (flags[idx] !== 1'b1 && cyc < 40000) begin
            @(negedge clk);
            cyc++;
        end
        clr(idx);
    endtask
    task automatic rd(input logic lo, input logic hi, input logic [3:0] acc);
        rd_lo = lo;
        rd_hi = hi;
        rd_acc = acc;
        @(negedge clk);
        rd_lo = 1'b0;
        rd_hi = 1'b0;
        rd_acc = 4'h0;
        @(negedge clk);
    endtask
    // Hang guard sized above the longest accumulation sweep
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        check(32'({flags, mod_en}), 32'h0);
        repeat (3) @(negedge clk);
        int_en = 3'h7;
        ctrl.enable = 1'b1;
        repeat (5) wait_ev(2, n);
        wait_ev(2, n);
        check_near(n, CT * RCP);
        check(32'(inst_result[15:12]), 32'h0);
        check(32'(inst_result[11:0] != 12'h000), 32'h1);
        repeat (CT * RCP + 8) @(negedge clk);
        check(32'({flags.inst, irq}), 32'h8);
        gie = 1'b1;
        @(negedge clk);
        check(32'(irq.inst), 32'h1);
        int_en.inst = 1'b0;
        @(negedge clk);
        check(32'(irq.inst), 32'h0);
        level = 1'b0;
        repeat (3) wait_ev(2, n);
        check(32'(inst_result[15:12]), 32'hf);
        rd(1'b1, 1'b0, 4'h0);
        held = 32'(inst_result);
        level = 1'b1;
        repeat (3 * CT * RCP) @(negedge clk);
        check(32'({flags.inst, inst_result}), held);
        rd(1'b0, 1'b1, 4'h0);
        wait_ev(2, n);
        check(32'(n <= CT * RCP + 4 && inst_result[15] == 1'b0), 32'h1);
        // A timely low-then-high read loses nothing: next result within one conversion
        rd(1'b1, 1'b0, 4'h0);
        rd(1'b0, 1'b1, 4'h0);
        wait_ev(2, n);
        check(32'(n <= CT * RCP), 32'h1);
        for (int s = 3; s >= 0; s--) begin
            ctrl.accum_sel = s[1:0];
            clr(1);
            wait_ev(1, n);
            wait_ev(1, n);
            check_near(n, (AT << s) * RCP);
            check(32'({accum_result[31:17], accum_result[16:0] != 17'h0}), 32'h1);
        end
        wait_ev(1, n);
        rd(1'b0, 1'b0, 4'h1);
        held = accum_result;
        level = 1'b0;
        repeat (2 * AT * RCP) @(negedge clk);
        check(accum_result, held);
        check(32'(flags.acc), 32'h0);
        for (int b = 1; b < 4; b++) rd(1'b0, 1'b0, 4'(1 << b));
        wait_ev(1, n);
        wait_ev(1, n);
        check(32'(accum_result[31]), 32'h1);
        ctrl.regular = 1'b1;
        ctrl.scale = 1'b1;
        level = 1'b1;
        repeat (2) @(negedge clk);
        held = accum_result;
        check(32'({mod_pol, ref_half}), 32'h1);
        for (int s = 3; s >= 0; s--) begin
            ctrl.interval_sel = s[1:0];
            clr(2);
            wait_ev(2, n);
            wait_ev(2, n);
            check_near(n, ((IT << s) + CT) * RCP);
        end
        check(accum_result, held);
        for (int t = 0; t < 4; t++) begin
            level = t[1];
            {chg_thr, dis_thr} = t[0] ? 16'h0101 : 16'hffff;
            wait_ev(2, n);
            clr(0);
            wait_ev(2, n);
            repeat (2) @(negedge clk);
            check(32'(flags.rc), 32'(t[0]));
        end
        ctrl.regular = 1'b0;
        ctrl.polarity = 1'b1;
        // Flipping polarity spoils the result in flight; leaving regular mode aborts no conversion
        repeat (5) wait_ev(2, n);
        check(32'(inst_result[15:12]), 32'hf);
        ctrl.enable = 1'b0;
        for (int p = 0; p < 2; p++) begin
            clr(2);
            repeat (3 * CT * RCP) @(negedge clk);
            check(32'({mod_en, flags.inst}), 32'h0);
            check(32'({mod_pol, ref_half}), 32'h2);
            ctrl.enable = 1'b1;
            power_off = 1'b1;
        end
        test_done();
    end
endmodule
